// ==== core/bhdl_load_unit.sv ====
// Purpose: decode and execute byte, halfword and doubleword loads
// Assumes: translation answers combinationally in the cycle it is asked
// Notes:   one instruction at a time, issued by an apb write
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/100ps

module bhdl_load_unit #(
  parameter int PADDR_W = 32
) (
  input  wire logic               pclk,             // apb clock
  input  wire logic               presetn,          // async reset, low
  input  wire logic               psel,             // apb select
  input  wire logic               penable,          // apb enable
  input  wire logic               pwrite,           // apb direction
  input  wire logic [7:0]         paddr,            // apb byte address
  input  wire logic [31:0]        pwdata,           // apb write data
  output logic      [31:0]        prdata,           // apb read data
  output logic                    pready,           // apb ready
  output logic                    pslverr,          // apb error
  output logic                    xlat_req,         // translation asked
  output logic      [31:0]        xlat_vaddr,       // address to map
  output logic                    xlat_usermap,     // use user mapping
  input  wire logic [PADDR_W-1:0] xlat_paddr,       // mapped address
  input  wire logic [2:0]         xlat_access_mode, // segment mode
  input  wire logic               xlat_refill,      // no entry found
  input  wire logic               xlat_invalid,     // entry invalid
  input  wire logic               watch_hit,        // watch matched
  output logic                    mem_req,          // read request
  output logic      [PADDR_W-1:0] mem_paddr,        // read address
  output logic      [31:0]        mem_vaddr,        // virtual address
  output logic      [1:0]         mem_size,         // access size
  input  wire logic               mem_ack,          // read done
  input  wire logic               mem_err,          // bus error
  input  wire logic [31:0]        mem_rdata,        // read word
  output logic                    wb_valid,         // commit pulse
  output logic      [1:0]         wb_kind,          // register file
  output logic      [4:0]         wb_index,         // register number
  output logic      [63:0]        wb_data,          // result value
  output logic                    exc_valid,        // exception pulse
  output logic      [2:0]         exc_code          // exception cause
);
  // instruction decode to an operation
  // primary opcode decode
  function automatic bhdl_pkg::bhdl_op_t decode_op(
    input logic [31:0] ins);
    logic [5:0] opc;
    opc = ins[bhdl_pkg::OPC_MSB:bhdl_pkg::OPC_LSB];
    decode_op = bhdl_pkg::op_none;
    if (opc == bhdl_pkg::OPC_LOAD_BYTE_UNSIGNED) begin
      decode_op = bhdl_pkg::op_load_byte_unsigned;
    end else if (opc == bhdl_pkg::OPC_LOAD_HALF_SIGNED) begin
      decode_op = bhdl_pkg::op_load_half_signed;
    end else if (opc == bhdl_pkg::OPC_LOAD_HALF_UNSIGNED) begin
      decode_op = bhdl_pkg::op_load_half_unsigned;
    end else if (opc == bhdl_pkg::OPC_LOAD_DOUBLE_TO_FPR) begin
      decode_op = bhdl_pkg::op_load_double_to_fpr;
    end else if (opc == bhdl_pkg::OPC_MAJOR_GROUP_B &&
                 ins[bhdl_pkg::SUB_MSB:bhdl_pkg::SUB_LSB] ==
                 bhdl_pkg::SUB_LOAD_DOUBLE_TO_COP2) begin
      decode_op = bhdl_pkg::op_load_double_to_cop2;
    end else if (opc == bhdl_pkg::OPC_MAJOR_GROUP_C &&
                 ins[bhdl_pkg::SUB_MSB:bhdl_pkg::SUB_LSB] ==
                 bhdl_pkg::SUB_USERMAP_LOAD_SUBGROUP) begin
      unique case (ins[bhdl_pkg::FN_MSB:bhdl_pkg::FN_LSB])
        bhdl_pkg::FN_BYTE_UNSIGNED_USERMAP:
          decode_op = bhdl_pkg::op_load_byte_unsigned_usermap;
        bhdl_pkg::FN_BYTE_SIGNED_USERMAP:
          decode_op = bhdl_pkg::op_load_byte_signed_usermap;
        bhdl_pkg::FN_HALF_SIGNED_USERMAP:
          decode_op = bhdl_pkg::op_load_half_signed_usermap;
        default: decode_op = bhdl_pkg::op_none;
      endcase
    end
  endfunction : decode_op
  // pick 8 or 16 bits at a byte lane and extend them
  function automatic logic [31:0] lane_extract(
    input logic [31:0] word, input logic [1:0] lane,
    input logic half, input logic signed_ext);
    logic [31:0] lane_word;
    lane_word = word >> {lane, 3'b000}; // lane 3 stays in range
    if (half) begin
      lane_extract = {{16{signed_ext & lane_word[15]}}, lane_word[15:0]};
    end else begin
      lane_extract = {{24{signed_ext & lane_word[7]}}, lane_word[7:0]};
    end
  endfunction : lane_extract
  // register and state storage
  logic [bhdl_pkg::CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [31:0]                 base_ff, nxt_base;
  logic [31:0]                 instr_ff, nxt_instr;
  logic                        done_ff, nxt_done;
  logic [31:0]                 prdata_ff, nxt_prdata;
  bhdl_pkg::bhdl_state_t       state_ff, nxt_state;
  bhdl_pkg::bhdl_exc_t         exc_ff, nxt_exc;
  logic [31:0]                 vaddr_ff, nxt_vaddr;
  logic [PADDR_W-1:0]          paddr_ff, nxt_paddr;
  logic [63:0]                 result_ff, nxt_result;
  // decoded view of the held instruction
  bhdl_pkg::bhdl_op_t op;
  logic        is_usermap, is_double, is_half, is_signed;
  logic [4:0]  dest;
  logic [1:0]  kind;
  logic [31:0] offset_ext;
  logic        eva_on, cop0_on, be_flag, re_flag;
  logic        apb_setup, apb_wr, mapped, start, clr_done;
  logic [31:0] ext_val;
  assign op         = decode_op(instr_ff);
  assign is_usermap = (op == bhdl_pkg::op_load_byte_unsigned_usermap) ||
                      (op == bhdl_pkg::op_load_byte_signed_usermap) ||
                      (op == bhdl_pkg::op_load_half_signed_usermap);
  assign is_double  = (op == bhdl_pkg::op_load_double_to_fpr) ||
                      (op == bhdl_pkg::op_load_double_to_cop2);
  assign is_half    = (op == bhdl_pkg::op_load_half_signed) ||
                      (op == bhdl_pkg::op_load_half_signed_usermap) ||
                      (op == bhdl_pkg::op_load_half_unsigned);
  assign is_signed  = (op == bhdl_pkg::op_load_half_signed) ||
                      (op == bhdl_pkg::op_load_half_signed_usermap) ||
                      (op == bhdl_pkg::op_load_byte_signed_usermap);
  assign dest       = instr_ff[bhdl_pkg::RT_MSB:bhdl_pkg::RT_LSB];
  assign kind       = (op == bhdl_pkg::op_load_double_to_fpr) ?
                      bhdl_pkg::KIND_FPR :
                      (op == bhdl_pkg::op_load_double_to_cop2) ?
                      bhdl_pkg::KIND_COP2 : bhdl_pkg::KIND_GPR;
  // offset width depends on the encoding family
  assign offset_ext = is_usermap ? {{23{instr_ff[8]}}, instr_ff[8:0]} :
                      (op == bhdl_pkg::op_load_double_to_cop2) ?
                      {{20{instr_ff[11]}}, instr_ff[11:0]} :
                      {{16{instr_ff[15]}}, instr_ff[15:0]};
  assign eva_on     = ctrl_ff[bhdl_pkg::CTRL_EVA_BIT];
  assign cop0_on    = ctrl_ff[bhdl_pkg::CTRL_COP0_BIT];
  assign be_flag    = ctrl_ff[bhdl_pkg::CTRL_BE_BIT];
  assign re_flag    = ctrl_ff[bhdl_pkg::CTRL_RE_BIT];
  // apb decode; zero wait states, so pready is tied high
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite;
  assign mapped    = paddr inside {bhdl_pkg::REG_CTRL, bhdl_pkg::REG_BASE,
                                   bhdl_pkg::REG_INSTR, bhdl_pkg::REG_STATUS,
                                   bhdl_pkg::REG_RES_LO, bhdl_pkg::REG_RES_HI};
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~mapped;
  assign prdata    = prdata_ff;
  // a new instruction is only taken while idle
  assign start     = apb_wr && (paddr == bhdl_pkg::REG_INSTR) &&
                     (state_ff == bhdl_pkg::st_idle);
  assign clr_done  = apb_wr && (paddr == bhdl_pkg::REG_STATUS) &&
                     pwdata[bhdl_pkg::ST_DONE_BIT];
  // register file next values; read data latched in the setup cycle
  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_base   = base_ff;
    nxt_instr  = instr_ff;
    nxt_prdata = prdata_ff;
    if (apb_wr && paddr == bhdl_pkg::REG_CTRL) begin
      nxt_ctrl = pwdata[bhdl_pkg::CTRL_W-1:0];
    end
    if (apb_wr && paddr == bhdl_pkg::REG_BASE) begin
      nxt_base = pwdata;
    end
    if (start) begin
      nxt_instr = pwdata;
    end
    if (apb_setup) begin
      unique case (paddr)
        bhdl_pkg::REG_CTRL:   nxt_prdata = {26'h0000000, ctrl_ff};
        bhdl_pkg::REG_BASE:   nxt_prdata = base_ff;
        bhdl_pkg::REG_INSTR:  nxt_prdata = instr_ff;
        bhdl_pkg::REG_STATUS: nxt_prdata = {20'h00000, dest, kind, exc_ff,
                                            done_ff,
                                            state_ff != bhdl_pkg::st_idle};
        bhdl_pkg::REG_RES_LO: nxt_prdata = result_ff[31:0];
        bhdl_pkg::REG_RES_HI: nxt_prdata = result_ff[63:32];
        default:              nxt_prdata = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff   <= bhdl_pkg::CTRL_RESET;
      base_ff   <= 32'h00000000;
      instr_ff  <= 32'h00000000;
      prdata_ff <= 32'h00000000;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      base_ff   <= nxt_base;
      instr_ff  <= nxt_instr;
      prdata_ff <= nxt_prdata;
    end
  end
  // byte or half picked from the first returned word
  // byte lane from big endian flag
  // half lane from big endian flag
  assign ext_val = lane_extract(mem_rdata, vaddr_ff[1:0] ^
                     (is_half ? {be_flag, 1'b0} : {2{be_flag}}),
                     is_half, is_signed);
  // execution sequencer
  always_comb begin
    nxt_state  = state_ff;
    nxt_exc    = exc_ff;
    nxt_vaddr  = vaddr_ff;
    nxt_paddr  = paddr_ff;
    nxt_result = result_ff;
    // sticky done: a hardware set beats a software clear
    nxt_done   = done_ff & ~clr_done;
    unique case (state_ff)
      bhdl_pkg::st_idle: begin
        if (start) begin
          nxt_state = bhdl_pkg::st_check;
          nxt_exc   = bhdl_pkg::exc_none;
          nxt_done  = 1'b0;
        end
      end
      bhdl_pkg::st_check: begin
        nxt_vaddr = base_ff + offset_ext;
        nxt_state = bhdl_pkg::st_xlat;
        if (op == bhdl_pkg::op_none || (is_usermap && !eva_on)) begin
          nxt_exc   = bhdl_pkg::exc_reserved_instr;
          nxt_state = bhdl_pkg::st_finish;
        end else if ((is_usermap && !cop0_on) ||
                     (op == bhdl_pkg::op_load_double_to_fpr &&
                      !ctrl_ff[bhdl_pkg::CTRL_COP1_BIT]) ||
                     (op == bhdl_pkg::op_load_double_to_cop2 &&
                      !ctrl_ff[bhdl_pkg::CTRL_COP2_BIT])) begin
          nxt_exc   = bhdl_pkg::exc_cop_unusable;
          nxt_state = bhdl_pkg::st_finish;
        end else if (is_double && nxt_vaddr[2:0] != 3'h0) begin
          nxt_exc   = bhdl_pkg::exc_addr_error;
          nxt_state = bhdl_pkg::st_finish;
        end else if (is_half && nxt_vaddr[0]) begin
          nxt_exc   = bhdl_pkg::exc_addr_error;
          nxt_state = bhdl_pkg::st_finish;
        end
      end
      bhdl_pkg::st_xlat: begin
        nxt_state = bhdl_pkg::st_read_lo;
        if (is_usermap &&
            xlat_access_mode != bhdl_pkg::AM_UNMAPPED_USER &&
            xlat_access_mode != bhdl_pkg::AM_MAPPED_USER &&
            xlat_access_mode != bhdl_pkg::AM_MAPPED_USER_KERNEL) begin
          nxt_exc   = bhdl_pkg::exc_cop_unusable;
          nxt_state = bhdl_pkg::st_finish;
        end else if (xlat_refill) begin
          nxt_exc   = bhdl_pkg::exc_tlb_refill;
          nxt_state = bhdl_pkg::st_finish;
        end else if (xlat_invalid) begin
          nxt_exc   = bhdl_pkg::exc_tlb_invalid;
          nxt_state = bhdl_pkg::st_finish;
        end else if (watch_hit) begin
          nxt_exc   = bhdl_pkg::exc_watch;
          nxt_state = bhdl_pkg::st_finish;
        end else if (is_double) begin
          nxt_paddr = xlat_paddr ^
                      {{(PADDR_W-3){1'b0}}, be_flag ^ re_flag, 2'b00};
        end else if (is_half) begin
          nxt_paddr = xlat_paddr ^ {{(PADDR_W-2){1'b0}}, re_flag, 1'b0};
        end else begin
          nxt_paddr = xlat_paddr ^ {{(PADDR_W-2){1'b0}}, {2{re_flag}}};
        end
      end
      bhdl_pkg::st_read_lo: begin
        if (mem_ack && mem_err) begin
          nxt_exc   = bhdl_pkg::exc_bus_error;
          nxt_state = bhdl_pkg::st_finish;
        end else if (mem_ack && is_double) begin
          nxt_result = {32'h00000000, mem_rdata};
          nxt_paddr  = paddr_ff ^
                       {{(PADDR_W-3){1'b0}}, bhdl_pkg::DW_HI_XOR};
          nxt_vaddr  = vaddr_ff + 32'h00000004;
          nxt_state  = bhdl_pkg::st_read_hi;
        end else if (mem_ack) begin
          nxt_result = {32'h00000000, ext_val};
          nxt_state  = bhdl_pkg::st_finish;
        end
      end
      bhdl_pkg::st_read_hi: begin
        if (mem_ack && mem_err) begin
          nxt_exc   = bhdl_pkg::exc_bus_error;
          nxt_state = bhdl_pkg::st_finish;
        end else if (mem_ack) begin
          nxt_result = {mem_rdata, result_ff[31:0]};
          nxt_state  = bhdl_pkg::st_finish;
        end
      end
      bhdl_pkg::st_finish: begin
        nxt_done  = 1'b1;
        nxt_state = bhdl_pkg::st_idle;
      end
      default: nxt_state = bhdl_pkg::st_idle;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff  <= bhdl_pkg::st_idle;
      exc_ff    <= bhdl_pkg::exc_none;
      done_ff   <= 1'b0;
      vaddr_ff  <= 32'h00000000;
      paddr_ff  <= '0;
      result_ff <= 64'h0000000000000000;
    end else begin
      state_ff  <= nxt_state;
      exc_ff    <= nxt_exc;
      done_ff   <= nxt_done;
      vaddr_ff  <= nxt_vaddr;
      paddr_ff  <= nxt_paddr;
      result_ff <= nxt_result;
    end
  end
  // translation and memory handshakes follow the state directly
  // usermap loads use the user mapping
  assign xlat_req     = (state_ff == bhdl_pkg::st_xlat);
  assign xlat_vaddr   = vaddr_ff;
  assign xlat_usermap = (state_ff == bhdl_pkg::st_xlat) & is_usermap;
  assign mem_req      = (state_ff == bhdl_pkg::st_read_lo) ||
                        (state_ff == bhdl_pkg::st_read_hi);
  assign mem_paddr    = paddr_ff;
  assign mem_vaddr    = vaddr_ff;
  assign mem_size     = is_double ? bhdl_pkg::SZ_WORD :
                        is_half ? bhdl_pkg::SZ_HALF : bhdl_pkg::SZ_BYTE;
  // completion; the result is only offered when nothing faulted
  // no commit after an exception
  assign wb_valid  = (state_ff == bhdl_pkg::st_finish) &&
                     (exc_ff == bhdl_pkg::exc_none);
  assign exc_valid = (state_ff == bhdl_pkg::st_finish) &&
                     (exc_ff != bhdl_pkg::exc_none);
  assign exc_code  = exc_ff;
  assign wb_kind   = kind;
  assign wb_index  = dest;
  assign wb_data   = result_ff;
endmodule : bhdl_load_unit

// ==== core/bhdl_pkg.sv ====
// Purpose: shared constants and types of the byte/half/double load unit
// Assumes: 32-bit instruction words, 32-bit virtual addresses
// Notes:   register offsets are byte addresses on the apb bus
package bhdl_pkg;
  // instruction fields
  localparam int OPC_MSB  = 31;
  localparam int OPC_LSB  = 26;
  localparam int RT_MSB   = 25;
  localparam int RT_LSB   = 21;
  localparam int BASE_MSB = 20;
  localparam int BASE_LSB = 16;
  localparam int SUB_MSB  = 15;
  localparam int SUB_LSB  = 12;
  localparam int FN_MSB   = 11;
  localparam int FN_LSB   = 9;
  // primary opcodes
  localparam logic [5:0] OPC_LOAD_BYTE_UNSIGNED   = 6'h05;
  localparam logic [5:0] OPC_MAJOR_GROUP_C        = 6'h18;
  localparam logic [5:0] OPC_LOAD_DOUBLE_TO_FPR   = 6'h2f;
  localparam logic [5:0] OPC_MAJOR_GROUP_B        = 6'h08;
  localparam logic [5:0] OPC_LOAD_HALF_SIGNED     = 6'h0f;
  localparam logic [5:0] OPC_LOAD_HALF_UNSIGNED   = 6'h0d;
  // minor codes
  localparam logic [3:0] SUB_USERMAP_LOAD_SUBGROUP = 4'h6;
  localparam logic [3:0] SUB_LOAD_DOUBLE_TO_COP2   = 4'h2;
  localparam logic [2:0] FN_BYTE_UNSIGNED_USERMAP  = 3'h0;
  localparam logic [2:0] FN_BYTE_SIGNED_USERMAP    = 3'h4;
  localparam logic [2:0] FN_HALF_SIGNED_USERMAP    = 3'h5;
  // register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_BASE    = 8'h04;
  localparam logic [7:0] REG_INSTR   = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0c;
  localparam logic [7:0] REG_RES_LO  = 8'h10;
  localparam logic [7:0] REG_RES_HI  = 8'h14;
  // control bits
  localparam int CTRL_EVA_BIT  = 0;
  localparam int CTRL_COP0_BIT = 1;
  localparam int CTRL_COP1_BIT = 2;
  localparam int CTRL_COP2_BIT = 3;
  localparam int CTRL_BE_BIT   = 4;
  localparam int CTRL_RE_BIT   = 5;
  localparam int CTRL_W        = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
  // status bits
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_EXC_LSB  = 2;
  localparam int ST_KIND_LSB = 5;
  localparam int ST_DEST_LSB = 7;
  // segment access modes reported by translation
  localparam logic [2:0] AM_UNMAPPED_USER      = 3'h1;
  localparam logic [2:0] AM_MAPPED_USER        = 3'h2;
  localparam logic [2:0] AM_MAPPED_USER_KERNEL = 3'h3;
  // memory access sizes and destination kinds
  localparam logic [1:0] SZ_BYTE   = 2'h0;
  localparam logic [1:0] SZ_HALF   = 2'h1;
  localparam logic [1:0] SZ_WORD   = 2'h2;
  localparam logic [1:0] KIND_GPR  = 2'h0;
  localparam logic [1:0] KIND_FPR  = 2'h1;
  localparam logic [1:0] KIND_COP2 = 2'h2;
  localparam logic [2:0] DW_HI_XOR = 3'h4;

  typedef enum logic [3:0] {
    op_none, op_load_byte_unsigned, op_load_byte_unsigned_usermap,
    op_load_byte_signed_usermap, op_load_half_signed,
    op_load_half_signed_usermap, op_load_half_unsigned,
    op_load_double_to_fpr, op_load_double_to_cop2
  } bhdl_op_t;

  typedef enum logic [2:0] {
    exc_none, exc_addr_error, exc_reserved_instr, exc_cop_unusable,
    exc_tlb_refill, exc_tlb_invalid, exc_bus_error, exc_watch
  } bhdl_exc_t;

  typedef enum logic [2:0] {
    st_idle, st_check, st_xlat, st_read_lo, st_read_hi, st_finish
  } bhdl_state_t;
endpackage : bhdl_pkg

// ==== sim/bhdl_load_unit_asserts.sv ====
// Purpose: port timing checks of the load unit
// Assumes: one clock, reset async low
// Notes:   watches outputs and the translation and memory inputs, bound below
`timescale 1ns/100ps
module bhdl_load_unit_asserts (
  input wire logic        pclk,             // clock
  input wire logic        presetn,          // reset, low
  input wire logic        xlat_req,         // translation asked
  input wire logic        xlat_usermap,     // user mapping
  input wire logic [2:0]  xlat_access_mode, // segment mode
  input wire logic        xlat_refill,      // no entry
  input wire logic        xlat_invalid,     // entry invalid
  input wire logic        watch_hit,        // watch matched
  input wire logic        mem_req,          // read request
  input wire logic        mem_ack,          // read done
  input wire logic        mem_err,          // bus error
  input wire logic [1:0]  mem_size,         // access size
  input wire logic [31:0] mem_vaddr,        // virtual address
  input wire logic        wb_valid,         // commit pulse
  input wire logic [1:0]  wb_kind,          // register file
  input wire logic [63:0] wb_data,          // result
  input wire logic        exc_valid,        // fault pulse
  input wire logic [2:0]  exc_code          // fault cause
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_nocm; exc_valid |-> !wb_valid; endproperty
  a_nocm: assert property (p_nocm) else $error("commit with fault");
  property p_wbp; wb_valid |=> !wb_valid && !exc_valid; endproperty
  a_wbp: assert property (p_wbp) else $error("commit too long");
  property p_gpr; wb_valid && wb_kind == 2'h0 |-> wb_data[63:32] == 32'h0;
  endproperty
  a_gpr: assert property (p_gpr) else $error("gpr upper bits set");
  property p_early; exc_valid && exc_code inside {3'h1, 3'h2}
    |-> !$past(xlat_req) && !$past(mem_req); endproperty
  a_early: assert property (p_early) else $error("late fault");
  property p_refl; xlat_req && xlat_refill && xlat_access_mode == 3'h3
    |=> exc_valid && exc_code == 3'h4; endproperty
  a_refl: assert property (p_refl) else $error("refill missed");
  property p_cu; xlat_req && xlat_usermap && xlat_access_mode == 3'h0
    |=> exc_valid && exc_code == 3'h3; endproperty
  a_cu: assert property (p_cu) else $error("bad segment passed");
  property p_go; xlat_req && !xlat_refill && !xlat_invalid && !watch_hit
    && xlat_access_mode inside {[3'h1:3'h3]} |=> mem_req; endproperty
  a_go: assert property (p_go) else $error("read not started");
  property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_vaddr);
  endproperty
  a_hold: assert property (p_hold) else $error("read dropped");
  property p_dbl; mem_req && mem_ack && !mem_err && mem_size == 2'h2
    && !mem_vaddr[2] |-> ##[1:3] (mem_req && mem_vaddr[2]); endproperty
  a_dbl: assert property (p_dbl) else $error("no second word");
endmodule : bhdl_load_unit_asserts
bind bhdl_load_unit bhdl_load_unit_asserts u_bhdl_load_unit_asserts (.*);

// ==== sim/bhdl_load_unit_tb.sv ====
// Purpose: self-checking bench of the load unit
// Assumes: zero-wait apb, byte value equals physical address
// Notes:   results read back through RES_LO and RES_HI
`timescale 1ns/100ps
module bhdl_load_unit_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        xlat_req, xlat_usermap, xlat_refill, xlat_invalid, se;
  logic        watch_hit, mem_req, mem_ack, mem_err, wb_valid;
  logic        exc_valid, err_on;
  logic [1:0]  mem_size, wb_kind, lat;
  logic [2:0]  xlat_access_mode, exc_code;
  logic [4:0]  wb_index;
  logic [6:0]  wbi;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, xlat_vaddr, xlat_paddr, mem_paddr;
  logic [31:0] mem_vaddr, mem_rdata, rd;
  logic [63:0] wb_data, last, wbd;
  int          errors, n_checks;
  bhdl_load_unit u_bhdl_load_unit (.*);
  bhdl_mem_model u_bhdl_mem_model (.*);
  always #2 pclk = ~pclk;
  // last commit seen on the write-back ports
  always @(posedge pclk) begin
    if (wb_valid === 1'b1) {wbi, wbd} <= {wb_index, wb_kind, wb_data};
  end
  task chk(input string n, input logic [63:0] s, input logic [63:0] x);
    n_checks++;
    if (s !== x) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // one apb transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function logic [31:0] pr(input logic [5:0] o, input logic [15:0] f);
    return {o, 5'd3, 5'd0, f};
  endfunction : pr
  function logic [31:0] um(input logic [2:0] f, input logic [8:0] o);
    return {6'h18, 5'd4, 5'd0, 4'h6, f, o};
  endfunction : um
  // issue, poll for done, compare cause and result
  task run(input logic [5:0] c, input logic [31:0] b, i,
           input logic [2:0] e, input logic [63:0] x);
    logic [31:0] lo;
    logic [1:0]  kd;
    kd = (i[31:26] == 6'h2f) ? 2'h1 : (i[31:26] == 6'h08) ? 2'h2 : 2'h0;
    apb(1'b1, bhdl_pkg::REG_CTRL, {26'h0, c});
    apb(1'b1, bhdl_pkg::REG_BASE, b);
    apb(1'b1, bhdl_pkg::REG_INSTR, i);
    rd = 32'h0;
    for (int k = 0; k < 30 && rd[1] !== 1'b1; k++)
      apb(1'b0, bhdl_pkg::REG_STATUS, 32'h0);
    chk("cause", rd[4:2], e);
    chk("dest", rd[11:5], {i[25:21], kd});
    if (e == 3'h0) chk("wb port", wbi, {i[25:21], kd});
    if (e == 3'h0) chk("wb data", wbd, x);
    if (e == 3'h0) last = x;
    apb(1'b0, bhdl_pkg::REG_RES_LO, 32'h0);
    lo = rd;
    apb(1'b0, bhdl_pkg::REG_RES_HI, 32'h0);
    chk("result", {rd, lo}, last);
  endtask : run
  task t_regs;
    apb(1'b0, bhdl_pkg::REG_CTRL, 32'h0);
    chk("ctrl", rd, 64'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", {se, rd}, 64'h1_0000_0000);
  endtask : t_regs
  task t_byte;
    run(6'h0f, 32'h1c3, pr(6'h05, 16'hfffe), 3'h0, 64'h81);
    run(6'h3f, 32'h1c3, pr(6'h05, 16'hfffe), 3'h0, 64'h82);
    run(6'h0f, 32'h1c2, um(3'h0, 9'h1ff), 3'h0, 64'h81);
    for (int m = 1; m < 4; m++) begin
      xlat_access_mode <= m[2:0];
      run(6'h0f, 32'h1c2, um(3'h4, 9'h1ff), 3'h0, 64'hffffff81);
    end
  endtask : t_byte
  task t_half;
    run(6'h0f, 32'h1c0, pr(6'h0f, 16'h0), 3'h0, 64'hffff8180);
    run(6'h0f, 32'h1c0, pr(6'h0d, 16'h0), 3'h0, 64'h8180);
    run(6'h0f, 32'h1c0, um(3'h5, 9'h0), 3'h0, 64'hffff8180);
    run(6'h1f, 32'h1c0, pr(6'h0f, 16'h0), 3'h0, 64'hffff8382);
    run(6'h0f, 32'h1c1, pr(6'h0d, 16'h0), 3'h1, 64'h0);
  endtask : t_half
  task t_dbl;
    lat <= 2'h2;
    run(6'h0f, 32'hf8, pr(6'h2f, 16'h8), 3'h0,
        64'h47464544_43424140);
    run(6'h1f, 32'h108, {6'h08, 10'h0, 4'h2, 12'hff8}, 3'h0,
        64'h43424140_47464544);
    run(6'h3f, 32'hf8, pr(6'h2f, 16'h8), 3'h0,
        64'h47464544_43424140);
    run(6'h0f, 32'hfc, pr(6'h2f, 16'h8), 3'h1, 64'h0);
    lat <= 2'h0;
  endtask : t_dbl
  task t_fault;
    logic [2:0] cd [4] = '{3'h4, 3'h5, 3'h7, 3'h6};
    run(6'h0e, 32'h1c2, um(3'h0, 9'h0), 3'h2, 64'h0);
    run(6'h0b, 32'hf8, pr(6'h2f, 16'h8), 3'h3, 64'h0);
    run(6'h0d, 32'h1c2, um(3'h0, 9'h0), 3'h3, 64'h0);
    run(6'h0f, 32'h1c2, 32'hfc000000, 3'h2, 64'h0);
    xlat_access_mode <= 3'h0;
    run(6'h0f, 32'h1c2, um(3'h0, 9'h0), 3'h3, 64'h0);
    xlat_access_mode <= 3'h3;
    for (int k = 0; k < 4; k++) begin
      {xlat_refill, xlat_invalid, watch_hit, err_on} <= 4'h8 >> k;
      run(6'h0f, 32'hf8, pr(6'h2f, 16'h8), cd[k], 64'h0);
    end
    {xlat_refill, xlat_invalid, watch_hit, err_on} <= 4'h0;
  endtask : t_fault
  task tally_and_finish;
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // stimulus: reset, then every scenario
  initial begin
    {pclk, presetn, psel, penable, pwrite, err_on} = 6'h0;
    {xlat_refill, xlat_invalid, watch_hit} = 3'h0;
    {paddr, pwdata, lat, last} = '0;
    xlat_access_mode = 3'h3;
    errors = 0;
    n_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs; t_byte; t_half; t_dbl; t_fault;
    tally_and_finish;
  end
  // watchdog, far beyond the expected several hundred cycles
  initial begin
    #200000;
    errors++;
    tally_and_finish;
  end
endmodule : bhdl_load_unit_tb

// ==== sim/bhdl_mem_model.sv ====
// Purpose: translation and memory beside the load unit
// Assumes: each byte holds its own physical address low byte
// Notes:   lat idle cycles before every ack
`timescale 1ns/100ps
module bhdl_mem_model (
  input  wire logic        pclk,       // clock
  input  wire logic [31:0] xlat_vaddr, // address to map
  output logic      [31:0] xlat_paddr, // mapped address
  input  wire logic        mem_req,    // read request
  input  wire logic [31:0] mem_paddr,  // read address
  input  wire logic [1:0]  lat,        // ack delay
  input  wire logic        err_on,     // answer with error
  output logic             mem_ack,    // read done
  output logic             mem_err,    // bus error
  output logic      [31:0] mem_rdata   // read word
);
  logic [1:0]  cnt_ff = 2'h0;
  logic        ack_ff = 1'b0;
  logic [31:0] dat_ff = 32'h0;
  logic [7:0]  wa;
  logic        go;
  // address bit 6 flipped so physical differs from virtual
  assign xlat_paddr = xlat_vaddr ^ 32'h40;
  assign wa = {mem_paddr[7:2], 2'h0};
  assign go = mem_req && !ack_ff && cnt_ff == lat;
  assign mem_ack = ack_ff;
  assign mem_err = ack_ff & err_on;
  assign mem_rdata = dat_ff;
  // word scrambled outside ack so stale data never matches
  always_ff @(posedge pclk) begin
    ack_ff <= go;
    cnt_ff <= (mem_req && !ack_ff && !go) ? cnt_ff + 2'h1 : 2'h0;
    dat_ff <= go ? {wa | 8'h3, wa | 8'h2, wa | 8'h1, wa} : ~dat_ff;
  end
endmodule : bhdl_mem_model
